// File: hw/host_port_pkg.sv
// Purpose: Shared constants for the serial host datagram port.
// Assumes: 40 MHz device clock.
// Notes: Frame layout and timing counts used by the port and its shifter.
package host_port_pkg;
  localparam int unsigned FRAME_BITS = 32;
  localparam int unsigned CNT_W = 6;
  localparam int unsigned DATA_BITS = 24;
  localparam int unsigned STATUS_BITS = 8;
  localparam int unsigned RW_BIT = 24;
  localparam int unsigned ADDR_LSB = 25;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned STATUS_IRQ_BIT = 0;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  localparam logic [CNT_W-1:0] CNT_FULL = 6'h20;
  localparam logic [CNT_W-1:0] CNT_HEADER = 6'h08;
  localparam logic [CNT_W-1:0] CNT_SETTLE = 6'h03;
  localparam logic [FRAME_BITS-1:0] FRAME_ZERO = 32'h0000_0000;
  localparam logic [DATA_BITS-1:0] DATA_ZERO = 24'h00_0000;
  localparam logic [7:0] PREDIV_RESET = 8'h0f;
  localparam logic [1:0] SYNC_IDLE = 2'h3;
  localparam real CLK_MHZ = 40.0;
  localparam int unsigned OUT_VALID_CYCLES = 4;
endpackage

// File: hw/host_port_sync.sv
// Purpose: Two-stage synchroniser with edge detection on the second stage.
// Assumes: Input is asynchronous to clk; idles high.
// Notes: First stage feeds only the second stage.
`timescale 1ns/10ps
module host_port_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule

// File: hw/serial_host_datagram_port.sv
// Purpose: Slave serial host port exchanging fixed 32-bit datagrams.
// Assumes: Host signals asynchronous to clk; host keeps the four-cycle timings.
// Notes: The register file lives outside; it answers read data combinationally.
// Contract
// - Shift in one host data bit on each rising serial clock edge.
// - Select rising copies the shift register into the command buffer.
// - Read data returns in the same frame, no later transfer needed.
// - Next output bit valid within four clocks of serial clock falling.
// - No timeout on bit timing; any long period is accepted.
// - While select is high, output carries the low-active interrupt.
// - Output pin is always driven, never released.
// - Frames are 32 bits each way, most significant bit first.
// - Host signals may be fully asynchronous to clk.
// - Every frame reports the current interrupt status.
// - Enabled switch or ramp conditions assert the low-active interrupt.
// - Reset clears register bits, pre-divider resets to fifteen.
// - Accesses ignored until reset completes and clock is stable.
// - Reply carries read data low 24 bits, status high 8.
// - One flag bit in the request selects read or write.
`timescale 1ns/10ps
module serial_host_datagram_port (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic host_select_n,
  input wire logic host_sclk,
  input wire logic host_sdi,
  output logic host_serial_out,
  input wire logic [host_port_pkg::ADDR_W-1:0] irq_conditions,
  input wire logic [host_port_pkg::ADDR_W-1:0] irq_enable,
  input wire logic [host_port_pkg::STATUS_BITS-1:0] status_bits,
  input wire logic [host_port_pkg::DATA_BITS-1:0] rd_data,
  output logic [host_port_pkg::ADDR_W-1:0] rd_addr,
  output logic [host_port_pkg::FRAME_BITS-1:0] cmd_data,
  output logic cmd_valid,
  output logic cmd_is_read,
  output logic irq_status_n,
  output logic [7:0] driver_clock_prediv
);
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_SHIFT} port_state_t;

  port_state_t state_q;
  logic sel_level;
  logic sel_rise;
  logic sel_fall;
  logic sck_level;
  logic sck_rise;
  logic sck_fall;
  logic sdi_meta_q;
  logic sdi_q;
  logic [host_port_pkg::FRAME_BITS-1:0] shift_q;
  logic [host_port_pkg::FRAME_BITS-1:0] reply_q;
  logic [host_port_pkg::CNT_W-1:0] count_q;
  logic out_q;
  logic [host_port_pkg::FRAME_BITS-1:0] cmd_q;
  logic valid_q;
  logic irq_q;
  logic [host_port_pkg::CNT_W-1:0] settle_q;
  logic port_ready;
  logic frame_full;
  logic frame_done;
  logic header_done;
  logic rd_is_read;
  logic prediv_hit;
  logic [host_port_pkg::ADDR_W-1:0] irq_masked;

  host_port_sync u_sel (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(host_select_n),
    .level(sel_level),
    .rise(sel_rise),
    .fall(sel_fall)
  );

  host_port_sync u_sck (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(host_sclk),
    .level(sck_level),
    .rise(sck_rise),
    .fall(sck_fall)
  );

  // Data rides the same two-stage delay as the clock so it aligns with the sampled edge.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sdi_meta_q <= 1'b0;
      sdi_q <= 1'b0;
    end else begin
      sdi_meta_q <= host_sdi;
      sdi_q <= sdi_meta_q;
    end
  end

  // Frame sequencing; no timeout anywhere so slow hosts are fine.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (sel_fall && port_ready) begin
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (sel_rise) begin
            state_q <= ST_IDLE;
          end else if (sck_fall) begin
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (sel_rise || sel_level) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // The port stays deaf until both synchronisers have flushed their reset value, so a
  // select edge seen while the clock settles cannot open a half frame.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settle_q <= host_port_pkg::CNT_ZERO;
    end else if (settle_q != host_port_pkg::CNT_SETTLE) begin
      settle_q <= settle_q + host_port_pkg::CNT_ONE;
    end
  end

  assign port_ready = (settle_q == host_port_pkg::CNT_SETTLE);

  // Bit counter; it saturates at a full frame so extra clocks cannot wrap it into a new one.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= host_port_pkg::CNT_ZERO;
    end else if (sel_fall) begin
      count_q <= host_port_pkg::CNT_ZERO;
    end else if (!sel_level && sck_rise && !frame_full) begin
      count_q <= count_q + host_port_pkg::CNT_ONE;
    end
  end

  assign frame_full = (count_q == host_port_pkg::CNT_FULL);

  // Input shifter, most significant bit first.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_q <= host_port_pkg::FRAME_ZERO;
    end else if (!sel_level && sck_rise && !frame_full) begin
      shift_q <= {shift_q[host_port_pkg::FRAME_BITS-2:0], sdi_q};
    end
  end

  // After eight bits the address sits in shift_q[6:1] and the direction flag in shift_q[0].
  assign rd_addr = shift_q[host_port_pkg::ADDR_W:1];
  assign rd_is_read = shift_q[host_port_pkg::RW_BIT - host_port_pkg::DATA_BITS];
  assign header_done = !sel_level && state_q == ST_SHIFT &&
                       count_q == host_port_pkg::CNT_HEADER;

  // Status is captured at select fall so the frame reports one consistent snapshot. Read
  // data is refreshed while the header is complete, which is before the falling clock that
  // sends its top bit even at the shortest legal high time.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reply_q <= host_port_pkg::FRAME_ZERO;
    end else if (sel_fall) begin
      reply_q <= {status_bits[host_port_pkg::STATUS_BITS-1:1], irq_q,
                  host_port_pkg::DATA_ZERO};
    end else if (header_done) begin
      reply_q[host_port_pkg::DATA_BITS-1:0] <= rd_is_read ?
        rd_data : host_port_pkg::DATA_ZERO;
    end
  end

  // Output bit: three clocks after the pin falls, inside the four-clock window.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_q <= 1'b1;
    end else if (sel_level) begin
      out_q <= irq_q;
    end else if (sck_fall && !frame_full) begin
      out_q <= reply_q[host_port_pkg::CNT_FULL[4:0] - 5'h01 - count_q[4:0]];
    end
  end

  assign host_serial_out = out_q;

  // Only a frame of at least 32 bits reaches the buffer; short frames are dropped.
  assign frame_done = sel_rise && frame_full && state_q == ST_SHIFT;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_q <= host_port_pkg::FRAME_ZERO;
    end else if (frame_done) begin
      cmd_q <= shift_q;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= frame_done;
    end
  end

  assign cmd_data = cmd_q;
  assign cmd_valid = valid_q;
  assign cmd_is_read = cmd_q[host_port_pkg::RW_BIT];

  // Each condition counts only while its enable is set.
  for (genvar gi = 0; gi < host_port_pkg::ADDR_W; gi++) begin : g_irq_mask
    assign irq_masked[gi] = irq_conditions[gi] & irq_enable[gi];
  end

  // Interrupt status is low-active and re-evaluated every cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_q <= 1'b1;
    end else begin
      irq_q <= ~|irq_masked;
    end
  end

  assign irq_status_n = irq_q;

  // A write to the all-ones address sets the pre-divider.
  assign prediv_hit = valid_q && !cmd_q[host_port_pkg::RW_BIT] &&
                      cmd_q[host_port_pkg::FRAME_BITS-2:host_port_pkg::ADDR_LSB] == '1;

  // The pre-divider resets to a nonzero value, as do irq_q and out_q.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      driver_clock_prediv <= host_port_pkg::PREDIV_RESET;
    end else if (prediv_hit) begin
      driver_clock_prediv <= cmd_q[7:0];
    end
  end
endmodule

// File: test/host_master.sv
// Purpose: Host side serial master issuing 32-bit frames.
// Assumes: Driven from the bench clock.
// Notes: Data input stays driven between frames.
`timescale 1ns/10ps
module host_master (
  input wire logic clk,
  output logic select_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    select_n = 1'b1;
    sclk = 1'b1;
    sdi = 1'b0;
  end
  task automatic frame(input logic [31:0] tx, input int half, output logic [31:0] rx);
    repeat (4) @(posedge clk);
    select_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 31; i >= 0; i--) begin
      sclk <= 1'b0;
      sdi <= tx[i];
      repeat (half) @(posedge clk);
      rx[i] = sdo;
      sclk <= 1'b1;
      repeat (half) @(posedge clk);
    end
    select_n <= 1'b1;
    sdi <= ~sdi;
  endtask
endmodule

// File: test/host_port_properties.sv
// Purpose: Port checker for the serial host datagram port.
// Assumes: Host uses serial clock halves of four or more cycles.
// Notes: Bound to the top module after the checker.
`timescale 1ns/10ps
module host_port_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic host_select_n,
  input wire logic host_sclk,
  input wire logic host_serial_out,
  input wire logic [5:0] irq_conditions,
  input wire logic [5:0] irq_enable,
  input wire logic [31:0] cmd_data,
  input wire logic cmd_valid,
  input wire logic cmd_is_read,
  input wire logic irq_status_n,
  input wire logic [7:0] driver_clock_prediv
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_IRQ_SET: assert property (
    $rose(|(irq_conditions & irq_enable)) |-> ##[1:2] !irq_status_n) else $error("irq late");
  AST_IDLE_OUT: assert property (
    host_select_n[*6] ##0 $stable(irq_status_n) |-> host_serial_out == irq_status_n)
    else $error("idle output differs");
  AST_VALID_AFTER: assert property (
    $rose(host_select_n) |-> ##[2:6] cmd_valid) else $error("no frame latch");
  AST_VALID_PULSE: assert property (
    cmd_valid |=> !cmd_valid) else $error("valid too long");
  AST_CMD_THEN_VALID: assert property (
    $changed(cmd_data) |-> cmd_valid) else $error("command changed alone");
  AST_READ_FLAG: assert property (
    cmd_valid |-> cmd_is_read == cmd_data[24]) else $error("read flag wrong");
  AST_READ_NO_WRITE: assert property (
    cmd_valid && cmd_is_read |=> $stable(driver_clock_prediv)) else $error("read wrote");
  AST_PREDIV: assert property (
    $changed(driver_clock_prediv) |-> cmd_data[30:24] == 7'h7e &&
    driver_clock_prediv == cmd_data[7:0]) else $error("prediv changed");
  AST_OUT_STABLE: assert property (
    $rose(host_sclk) && !host_select_n |-> $stable(host_serial_out))
    else $error("output late");
  cover property (cmd_valid && cmd_is_read);
  cover property (cmd_valid && !cmd_is_read);
  cover property (!irq_status_n && host_select_n);
endmodule
bind serial_host_datagram_port host_port_properties u_props (.clk, .rst_b, .host_select_n,
  .host_sclk, .host_serial_out, .irq_conditions, .irq_enable, .cmd_data, .cmd_valid,
  .cmd_is_read, .irq_status_n, .driver_clock_prediv);

// File: test/serial_host_datagram_port_tb.sv
// Purpose: Self-checking bench for the serial host datagram port.
// Assumes: Read data is a fixed pattern of the read address.
// Notes: Frames are driven by the host model.
`timescale 1ns/10ps
module serial_host_datagram_port_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic select_n, sclk, sdi, sdo, valid, is_rd, irq_n;
  logic [5:0] cond = 6'h00;
  logic [5:0] en = 6'h00;
  logic [7:0] stat = 8'ha4;
  logic [5:0] addr;
  logic [7:0] prediv;
  logic [31:0] cmd, rx, rx0;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int valid_pulses = 0;
  wire logic [23:0] rdat = {3{2'b10, addr}};
  always #12.5 clk = ~clk;
  serial_host_datagram_port u_dut (.clk, .rst_b, .host_select_n(select_n), .host_sclk(sclk),
    .host_sdi(sdi), .host_serial_out(sdo), .irq_conditions(cond), .irq_enable(en),
    .status_bits(stat), .rd_data(rdat), .rd_addr(addr), .cmd_data(cmd), .cmd_valid(valid),
    .cmd_is_read(is_rd), .irq_status_n(irq_n), .driver_clock_prediv(prediv));
  host_master u_host (.clk, .select_n, .sclk, .sdi, .sdo);
  function automatic bit seen(bit differ);
    samples_checked++;
    return differ;
  endfunction
  task automatic wrong(input string msg);
    bad_count++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask
  task automatic tally_and_finish();
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // A very slow frame shows that bit timing has no timeout.
  task automatic prediv_write();
    if (seen(prediv !== 8'h0f)) wrong("prediv reset");
    u_host.frame({1'b0, 6'h3f, 1'b0, 24'h00_0033}, 40, rx);
    repeat (6) @(posedge clk);
    if (seen(prediv !== 8'h33)) wrong("prediv write");
    if (seen(is_rd !== 1'b0)) wrong("write flag");
    if (seen(valid_pulses != 1)) wrong("write frame latch count");
  endtask
  task automatic read_frame();
    u_host.frame({1'b0, 6'h15, 1'b1, 24'h00_0000}, 4, rx0);
    repeat (6) @(posedge clk);
    if (seen(rx0[23:0] !== 24'h95_9595)) wrong("read data");
    if (seen(rx0[31:25] !== stat[7:1])) wrong("status bits");
    if (seen(cmd !== 32'h2b00_0000)) wrong("command word");
    if (seen(is_rd !== 1'b1)) wrong("read flag");
    if (seen(rx0[24] !== 1'b1)) wrong("idle irq bit");
    if (seen(valid_pulses != 2)) wrong("read frame latch count");
  endtask
  task automatic irq_frame();
    cond <= 6'h04;
    repeat (5) @(posedge clk);
    if (seen(irq_n !== 1'b1 || sdo !== 1'b1)) wrong("masked irq");
    en <= 6'h0c;
    repeat (5) @(posedge clk);
    if (seen(irq_n !== 1'b0 || sdo !== 1'b0)) wrong("irq output");
    u_host.frame({1'b0, 6'h15, 1'b1, 24'h00_0000}, 4, rx);
    if (seen(rx[24] !== 1'b0 || rx[23:0] !== 24'h95_9595)) wrong("irq bit");
    cond <= 6'h00;
    repeat (5) @(posedge clk);
    if (seen(irq_n !== 1'b1)) wrong("irq clear");
    if (seen(valid_pulses != 3)) wrong("irq frame latch count");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    prediv_write();
    read_frame();
    irq_frame();
    tally_and_finish();
  end
  always @(posedge clk) begin
    if (valid === 1'b1) valid_pulses++;
    cycles++;
    if (cycles == 20000) begin
      wrong("timeout");
      tally_and_finish();
    end
  end
endmodule
